// [mcl_board.sv]
// Purpose: Board-side model of one I/O pin facing the macrocell
// Assumes: Single ref_clk domain, requests made by the bench
// Notes:   A released, undriven pin shows the inverse of its last level
`default_nettype none
module mcl_board (
   input  wire logic ref_clk,
   input  wire logic drv_req,
   input  wire logic drv_val,
   input  wire logic io_out,
   input  wire logic io_oe,
   output logic      io_in,
   output logic      io_drv
);
   timeunit 1ns;
   timeprecision 100ps;

   logic last_reg;

   ////////////////////////////////////////////////////////////////////////
   // Last level seen on the wire
   always_ff @(posedge ref_clk) begin
      if (drv_req) begin
         last_reg <= drv_val;
      end else if (io_oe) begin
         last_reg <= io_out;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Wire level from both parties; no pull on this pin
   assign io_drv = drv_req;
   always_comb begin
      if (io_oe) begin
         io_in = io_out;
      end else if (drv_req) begin
         io_in = drv_val;
      end else begin
         io_in = ~last_reg;
      end
   end
endmodule
`default_nettype wire

// [mcl_macrocell.sv]
// Purpose: One macrocell with storage, routing, keeper and power-down
// Assumes: All pins synchronous to ref_clk; srst is power-up reset
// Notes:   Pin clocks are edge-detected samples of ref_clk
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Contract
// R01 - XOR of sum with term or constant
// R02 - XOR feedback emulates toggle and JK
// R03 - Data from XOR, term or pin
// R04 - Latch transparent high, holds low
// R05 - Clock global or term, rising edge
// R06 - Low enable ignores global clock edges
// R07 - Clear from global, term, both, off
// R08 - Preset from term or off
// R09 - Output and feedback registered or combinational
// R10 - Output enable from pins or cells
// R11 - Pin input, output or bidirectional
// R12 - Matrix picks up to forty bus signals
// R13 - Inverted foldback term onto regional bus
// R14 - Keeper holds last driven pin level; code keeps only board-driven levels, not its own output
// R15 - Power-down pin freezes logic and outputs
// R16 - Pin changes ignored while powered down
// R17 - Power-down pin not logic, foldback kept
// R18 - Reset clears registers, outputs take polarity
// R19 - Board meets setup before clocking
// R20 - Optional standby when inputs idle
// R21 - Clear beats preset when both active
module mcl_macrocell #(
   parameter int N_GBUS = 68,
   parameter int N_MTX  = 40,
   parameter int DW     = 32
) (
   input  wire  logic              ref_clk,
   input  wire  logic              srst,
   input  wire  logic [3:0]        addr,
   input  wire  logic [DW-1:0]     wdata,
   input  wire  logic              wr_stb,
   input  wire  logic              rd_stb,
   output logic [DW-1:0]           rdata,
   input  wire  logic [2:0]        global_clock_pins,
   input  wire  logic              global_clear_input,
   input  wire  logic [1:0]        oe_pins,
   input  wire  logic [3:0]        oe_io_pins,
   input  wire  logic [3:0]        oe_mc_outs,
   input  wire  logic              powerdown_pin_a,
   input  wire  logic              powerdown_pin_b,
   input  wire  logic [N_GBUS-1:0] gbus,
   input  wire  logic [4:0]        pterm,
   input  wire  logic [3:0]        foldback_in,
   input  wire  logic              cascade_in,
   input  wire  logic              io_in,
   input  wire  logic              io_drv,
   output logic                    io_out,
   output logic                    io_oe,
   output logic                    feedback_out,
   output logic                    foldback_out,
   output logic                    cascade_out,
   output logic [N_MTX-1:0]        matrix_out,
   output logic                    powered_down,
   output logic                    standby
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   mcl_pkg::mcl_core_t             core_reg;
   mcl_pkg::mcl_io_t               io_reg;
   logic [mcl_pkg::MTX_SRC_W-1:0]  mtx_sel [N_MTX];
   logic [N_GBUS-1:0]              gbus_q;
   logic [4:0]                     pt_q;
   logic [3:0]                     fold_q;
   logic                           cas_q;
   logic [2:0]                     gck_q;
   logic                           gclr_q;
   logic                           clk_prev;
   logic                           q_reg;
   logic                           keep_reg;
   logic                           pd_act;
   logic                           clk_lvl;
   logic                           clk_rise;
   logic                           ce_ok;
   logic                           ar_act;
   logic                           ap_act;
   logic                           sum_term;
   logic                           xor_b;
   logic                           xor_out;
   logic                           pin_level;
   logic                           d_in;
   logic                           oe_mux;
   logic                           oe_val;
   logic                           q_next;
   localparam int MTX_ENT_W_L = mcl_pkg::MTX_ENT_W;
   logic [MTX_ENT_W_L-1:0]         w_ent;

   assign w_ent = wdata[mcl_pkg::MTX_ENT_LSB +: MTX_ENT_W_L];

   ////////////////////////////////////////////////////////////////////////
   // Power-down detect
   assign pd_act = core_reg.pd_en
                 & (powerdown_pin_a | powerdown_pin_b);        // [R15]

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         powered_down <= 1'b0;
      end else begin
         powered_down <= pd_act;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register port
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         core_reg <= mcl_pkg::mcl_core_t'(mcl_pkg::CORE_RST);
         io_reg   <= mcl_pkg::mcl_io_t'(mcl_pkg::IO_RST);
      end else if (wr_stb && addr == mcl_pkg::REG_CORE) begin
         core_reg <= mcl_pkg::mcl_core_t'(wdata[17:0]);
      end else if (wr_stb && addr == mcl_pkg::REG_IO) begin
         io_reg <= mcl_pkg::mcl_io_t'(wdata[18:0]);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         for (int i = 0; i < N_MTX; i++) begin
            mtx_sel[i] <= '0;
         end
      end else if (wr_stb && addr == mcl_pkg::REG_MTX
                   && int'(w_ent) < N_MTX) begin
         mtx_sel[w_ent] <= wdata[mcl_pkg::MTX_SRC_W-1:0];      // [R12]
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rdata <= '0;
      end else if (rd_stb) begin
         unique case (addr)
            mcl_pkg::REG_CORE: rdata <= DW'(core_reg);
            mcl_pkg::REG_IO:   rdata <= DW'(io_reg);
            mcl_pkg::REG_STAT: rdata <= DW'({standby, powered_down,
                                             keep_reg, io_oe, q_reg});
            default:           rdata <= '0;
         endcase
      end else begin
         rdata <= '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin sampling, frozen in power-down
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         gbus_q <= '0;
         pt_q   <= '0;
         fold_q <= '0;
         cas_q  <= 1'b0;
         gck_q  <= '0;
         gclr_q <= 1'b0;
      end else if (!pd_act) begin                              // [R16]
         gbus_q <= gbus;
         pt_q   <= pterm;
         fold_q <= foldback_in;
         cas_q  <= cascade_in;
         gck_q  <= global_clock_pins;
         gclr_q <= global_clear_input;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sum, XOR and storage control
   assign sum_term = |(pt_q & io_reg.sum_mask) | cas_q
                   | |(fold_q & io_reg.fold_mask);             // [R13]

   always_comb begin
      unique case (core_reg.xor_sel)                           // [R01]
         mcl_pkg::XOR_PT: xor_b = pt_q[mcl_pkg::PT_XOR];
         mcl_pkg::XOR_LO: xor_b = 1'b0;
         mcl_pkg::XOR_HI: xor_b = 1'b1;
         mcl_pkg::XOR_Q:  xor_b = q_reg;                       // [R02]
      endcase
   end
   assign xor_out = sum_term ^ xor_b;

   assign pin_level = io_oe ? io_out
                    : io_drv ? io_in
                    : (core_reg.keeper & keep_reg);            // [R14]

   always_comb begin
      unique case (core_reg.d_sel)                             // [R03]
         mcl_pkg::D_PT:  d_in = pt_q[mcl_pkg::PT_DATA];
         mcl_pkg::D_PIN: d_in = pin_level & ~core_reg.pd_own;  // [R17]
         default:        d_in = xor_out;
      endcase
   end

   assign clk_lvl = (core_reg.clk_sel == mcl_pkg::CLK_PT)
                  ? pt_q[mcl_pkg::PT_CLK]
                  : gck_q[core_reg.clk_sel];                   // [R05]
   assign clk_rise = clk_lvl & ~clk_prev;
   assign ce_ok = (core_reg.clk_sel == mcl_pkg::CLK_PT)
                | ~core_reg.ce_en | pt_q[mcl_pkg::PT_CE];      // [R06]

   always_comb begin
      unique case (core_reg.ar_sel)                            // [R07]
         mcl_pkg::AR_OFF:  ar_act = 1'b0;
         mcl_pkg::AR_GCLR: ar_act = gclr_q;
         mcl_pkg::AR_PT:   ar_act = pt_q[mcl_pkg::PT_AR];
         mcl_pkg::AR_BOTH: ar_act = gclr_q | pt_q[mcl_pkg::PT_AR];
      endcase
   end
   assign ap_act = core_reg.ap_en & pt_q[mcl_pkg::PT_AP];      // [R08]

   always_comb begin
      q_next = q_reg;
      if (ar_act) begin
         q_next = 1'b0;                                        // [R21]
      end else if (ap_act) begin
         q_next = 1'b1;
      end else if (core_reg.latch) begin
         if (clk_lvl) begin
            q_next = d_in;                                     // [R04]
         end
      end else if (clk_rise && ce_ok) begin
         q_next = d_in;                                        // [R05]
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         q_reg    <= 1'b0;                                     // [R18]
         clk_prev <= 1'b0;
      end else if (!pd_act) begin                              // [R15]
         q_reg    <= q_next;
         clk_prev <= clk_lvl;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output enable selection
   always_comb begin
      unique case (io_reg.oe_sel)                              // [R10]
         mcl_pkg::OE_P0:    oe_mux = oe_pins[0];
         mcl_pkg::OE_P0_N:  oe_mux = ~oe_pins[0];
         mcl_pkg::OE_P1:    oe_mux = oe_pins[1];
         mcl_pkg::OE_P1_N:  oe_mux = ~oe_pins[1];
         mcl_pkg::OE_IOPIN: oe_mux = oe_io_pins[io_reg.oe_idx];
         mcl_pkg::OE_MC:    oe_mux = oe_mc_outs[io_reg.oe_idx];
         mcl_pkg::OE_ON:    oe_mux = 1'b1;
         default:           oe_mux = 1'b0;
      endcase
   end

   always_comb begin
      unique case (io_reg.io_mode)                             // [R11]
         mcl_pkg::IO_IN:  oe_val = 1'b0;
         mcl_pkg::IO_OUT: oe_val = 1'b1;
         default:         oe_val = oe_mux;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin, feedback and keeper outputs
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         io_out       <= mcl_pkg::CORE_RST[13];                // [R18]
         io_oe        <= 1'b0;
         feedback_out <= 1'b0;
         foldback_out <= 1'b0;
         cascade_out  <= 1'b0;
         keep_reg     <= 1'b0;
      end else if (!pd_act) begin                              // [R15]
         io_out       <= (core_reg.out_reg ? q_reg : xor_out)
                       ^ core_reg.out_pol;                     // [R09]
         io_oe        <= oe_val & ~core_reg.pd_own;            // [R17]
         feedback_out <= core_reg.fb_reg ? q_reg : xor_out;    // [R09]
         foldback_out <= ~pt_q[io_reg.fold_sel];               // [R13]
         cascade_out  <= sum_term;
         if (io_drv && !io_oe) begin
            keep_reg <= io_in;                                 // [R14]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Switch matrix
   genvar e;
   generate
      for (e = 0; e < N_MTX; e++) begin : g_mtx
         always_ff @(posedge ref_clk) begin
            if (srst) begin
               matrix_out[e] <= 1'b0;
            end else if (!pd_act) begin
               matrix_out[e] <= (int'(mtx_sel[e]) < N_GBUS)
                              ? gbus_q[mtx_sel[e]] : 1'b0;     // [R12]
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Standby detect
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         standby <= 1'b0;
      end else begin
         standby <= core_reg.stby_en & (gbus == gbus_q)
                  & (pterm == pt_q);                           // [R20]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   property p_clear_wins;
      @(posedge ref_clk) disable iff (srst)
      (ar_act && ap_act && !pd_act) |=> !q_reg;
   endproperty
   a_clear_wins: assert property (p_clear_wins)                // [R21]
      else $error("clear lost to preset");

   property p_preset;
      @(posedge ref_clk) disable iff (srst)
      (ap_act && !ar_act && !pd_act) |=> q_reg;
   endproperty
   a_preset: assert property (p_preset)                        // [R08]
      else $error("preset did not set storage");

   property p_pd_freeze;
      @(posedge ref_clk) disable iff (srst)
      pd_act |=> $stable(q_reg) && $stable(io_out) && $stable(io_oe);
   endproperty
   a_pd_freeze: assert property (p_pd_freeze)                  // [R15]
      else $error("state moved in power-down");

   property p_pd_ignore;
      @(posedge ref_clk) disable iff (srst)
      pd_act |=> $stable(gbus_q) && $stable(gck_q);
   endproperty
   a_pd_ignore: assert property (p_pd_ignore)                  // [R16]
      else $error("pin change seen in power-down");

   property p_own_quiet;
      @(posedge ref_clk) disable iff (srst)
      (core_reg.pd_own && !pd_act) |=> !io_oe;
   endproperty
   a_own_quiet: assert property (p_own_quiet)                  // [R17]
      else $error("power-down pin driven");

   property p_ce_block;
      @(posedge ref_clk) disable iff (srst)
      (!pd_act && !ar_act && !ap_act && !core_reg.latch
       && core_reg.clk_sel != mcl_pkg::CLK_PT && core_reg.ce_en
       && !pt_q[mcl_pkg::PT_CE]) |=> $stable(q_reg);
   endproperty
   a_ce_block: assert property (p_ce_block)                    // [R06]
      else $error("edge taken with enable low");

   property p_latch_hold;
      @(posedge ref_clk) disable iff (srst)
      (!pd_act && !ar_act && !ap_act && core_reg.latch && !clk_lvl)
      |=> $stable(q_reg);
   endproperty
   a_latch_hold: assert property (p_latch_hold)                // [R04]
      else $error("latch changed with clock low");

   property p_edge_load;
      @(posedge ref_clk) disable iff (srst)
      (!pd_act && !ar_act && !ap_act && !core_reg.latch && clk_rise
       && ce_ok) |=> q_reg == $past(d_in);
   endproperty
   a_edge_load: assert property (p_edge_load)                  // [R05]
      else $error("rising edge did not load data");

   property p_keeper;
      @(posedge ref_clk) disable iff (srst)
      (!pd_act && io_drv && !io_oe) ##1 (!pd_act && !io_drv && !io_oe
       && core_reg.keeper) |-> pin_level == $past(io_in, 1);
   endproperty
   a_keeper: assert property (p_keeper)                        // [R14]
      else $error("keeper lost driven level");

endmodule
`default_nettype wire

// [mcl_pkg.sv]
// Purpose: Shared constants and config layouts for the macrocell model
// Assumes: Word-indexed register port, one clock
// Notes:   Field layouts are packed structs, LSB last
`default_nettype none
package mcl_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register indices
   localparam logic [3:0] REG_CORE = 4'h0;
   localparam logic [3:0] REG_IO   = 4'h1;
   localparam logic [3:0] REG_STAT = 4'h2;
   localparam logic [3:0] REG_MTX  = 4'h3;

   ////////////////////////////////////////////////////////////////////////
   // Config layouts
   typedef struct packed {
      logic       stby_en;
      logic       pd_own;
      logic       pd_en;
      logic       keeper;
      logic       out_pol;
      logic       fb_reg;
      logic       out_reg;
      logic       ap_en;
      logic [1:0] ar_sel;
      logic       ce_en;
      logic [1:0] clk_sel;
      logic       latch;
      logic [1:0] d_sel;
      logic [1:0] xor_sel;
   } mcl_core_t;

   typedef struct packed {
      logic [3:0] fold_mask;
      logic [2:0] fold_sel;
      logic [4:0] sum_mask;
      logic [1:0] oe_idx;
      logic [2:0] oe_sel;
      logic [1:0] io_mode;
   } mcl_io_t;

   localparam logic [17:0] CORE_RST = 18'h00000;
   localparam logic [18:0] IO_RST   = 19'h00F81;

   ////////////////////////////////////////////////////////////////////////
   // Matrix write fields
   localparam int MTX_ENT_LSB = 16;
   localparam int MTX_ENT_W   = 6;
   localparam int MTX_SRC_W   = 7;

   ////////////////////////////////////////////////////////////////////////
   // Select encodings
   localparam logic [1:0] XOR_PT   = 2'h0;
   localparam logic [1:0] XOR_LO   = 2'h1;
   localparam logic [1:0] XOR_HI   = 2'h2;
   localparam logic [1:0] XOR_Q    = 2'h3;
   localparam logic [1:0] D_XOR    = 2'h0;
   localparam logic [1:0] D_PT     = 2'h1;
   localparam logic [1:0] D_PIN    = 2'h2;
   localparam logic [1:0] CLK_PT   = 2'h3;
   localparam logic [1:0] AR_OFF   = 2'h0;
   localparam logic [1:0] AR_GCLR  = 2'h1;
   localparam logic [1:0] AR_PT    = 2'h2;
   localparam logic [1:0] AR_BOTH  = 2'h3;
   localparam logic [1:0] IO_IN    = 2'h0;
   localparam logic [1:0] IO_OUT   = 2'h1;
   localparam logic [2:0] OE_P0    = 3'h0;
   localparam logic [2:0] OE_P0_N  = 3'h1;
   localparam logic [2:0] OE_P1    = 3'h2;
   localparam logic [2:0] OE_P1_N  = 3'h3;
   localparam logic [2:0] OE_IOPIN = 3'h4;
   localparam logic [2:0] OE_MC    = 3'h5;
   localparam logic [2:0] OE_ON    = 3'h6;

   ////////////////////////////////////////////////////////////////////////
   // Product term roles
   localparam int PT_AP   = 0;
   localparam int PT_AR   = 1;
   localparam int PT_CLK  = 2;
   localparam int PT_CE   = 2;
   localparam int PT_DATA = 3;
   localparam int PT_XOR  = 4;

endpackage
`default_nettype wire

// [pld_macrocell_register_logic_tb.sv]
// Purpose: Self-checking bench for the macrocell model
// Assumes: Register port as in the package; pin model in mcl_board
// Notes:   Storage is read back through the status word
`default_nettype none
module pld_macrocell_register_logic_tb;
   timeunit 1ns;
   timeprecision 100ps;

   logic ref_clk, srst, wr_stb, rd_stb, io_in, io_drv, drv_req, drv_val;
   logic [3:0]  addr;
   logic [31:0] wdata, rdata, d;
   logic [2:0]  global_clock_pins;
   logic        global_clear_input, powerdown_pin_a, powerdown_pin_b;
   logic [1:0]  oe_pins;
   logic [3:0]  oe_io_pins, oe_mc_outs;
   logic [67:0] gbus;
   logic [4:0]  pterm;
   logic [3:0]  fold_in;
   logic        io_out, io_oe, feedback_out, foldback_out, powered_down;
   logic        standby, cascade_out;
   logic [39:0] matrix_out;
   int          bad_count, total_checks;
   mcl_pkg::mcl_core_t c;
   mcl_pkg::mcl_io_t   io;
   logic [2:0]  oe_tab [8];
   logic        oe_exp [8];

   mcl_macrocell dut_u (.ref_clk(ref_clk), .srst(srst), .addr(addr),
      .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
      .global_clock_pins(global_clock_pins),
      .global_clear_input(global_clear_input), .oe_pins(oe_pins),
      .oe_io_pins(oe_io_pins), .oe_mc_outs(oe_mc_outs),
      .powerdown_pin_a(powerdown_pin_a), .powerdown_pin_b(powerdown_pin_b),
      .gbus(gbus), .pterm(pterm), .foldback_in(fold_in), .cascade_in(1'b0),
      .io_in(io_in), .io_drv(io_drv), .io_out(io_out), .io_oe(io_oe),
      .feedback_out(feedback_out), .foldback_out(foldback_out),
      .cascade_out(cascade_out), .matrix_out(matrix_out),
      .powered_down(powered_down), .standby(standby));

   mcl_board board_u (.ref_clk(ref_clk), .drv_req(drv_req),
      .drv_val(drv_val), .io_out(io_out), .io_oe(io_oe), .io_in(io_in),
      .io_drv(io_drv));

   ////////////////////////////////////////////////////////////////////////
   // Clock, watchdog, verdict
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   initial begin
      repeat (20000) @(posedge ref_clk);
      bad_count++;
      give_verdict();
   end

   task automatic give_verdict();
      $display("checks %0d errors %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Access and compare tasks
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      addr   <= a;
      wdata  <= v;
      wr_stb <= 1'b1;
      @(posedge ref_clk);
      wr_stb <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge ref_clk);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge ref_clk);
      rd_stb <= 1'b0;
      #1 v = rdata;
   endtask

   task automatic chk_reg(input string n, input logic [31:0] e,
                          input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chk_pin(input string n, input logic e, input logic g);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("Error %s expected %b seen %b", n, e, g);
      end
   endtask

   task automatic qchk(input logic e);
      rd(mcl_pkg::REG_STAT, d);
      chk_pin("q", e, d[0]);
   endtask

   task automatic wc();
      wr(mcl_pkg::REG_CORE, 32'(c));
      step(3);
   endtask

   task automatic wi();
      wr(mcl_pkg::REG_IO, 32'(io));
      step(3);
   endtask

   task automatic pt(input logic [4:0] v);
      @(posedge ref_clk);
      pterm <= v;
      step(3);
   endtask

   task automatic gpulse();
      @(posedge ref_clk);
      global_clock_pins <= 3'h1;
      step(2);
      global_clock_pins <= 3'h0;
      step(3);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Tests
   initial begin
      {srst, wr_stb, rd_stb, drv_req, drv_val} = 5'h10;
      {global_clear_input, powerdown_pin_a, powerdown_pin_b} = 3'h0;
      {addr, wdata, global_clock_pins, pterm} = '0;
      {oe_pins, oe_io_pins, oe_mc_outs, gbus, fold_in} = '0;
      {bad_count, total_checks} = '0;
      step(20);
      srst <= 1'b0;
      rd(mcl_pkg::REG_CORE, d);
      chk_reg("core", 32'(mcl_pkg::CORE_RST), d);
      rd(mcl_pkg::REG_IO, d);
      chk_reg("io", 32'(mcl_pkg::IO_RST), d);
      rd(4'h7, d);
      chk_reg("unmapped", 32'h0, d);
      qchk(1'b0);
      chk_pin("io_out", 1'b0, io_out);
      io = mcl_pkg::IO_RST;
      c = '0;
      c.d_sel = mcl_pkg::D_PT;
      wc();
      pt(5'h08);
      gpulse();
      qchk(1'b1);
      pt(5'h00);
      qchk(1'b1);
      c.clk_sel = mcl_pkg::CLK_PT;
      wc();
      pt(5'h04);
      qchk(1'b0);
      pt(5'h08);
      pt(5'h0C);
      qchk(1'b1);
      pt(5'h00);
      qchk(1'b1);
      c.clk_sel = 2'h0;
      c.ce_en = 1'b1;
      wc();
      gpulse();
      qchk(1'b1);
      pt(5'h04);
      gpulse();
      qchk(1'b0);
      c.ce_en = 1'b0;
      c.latch = 1'b1;
      wc();
      global_clock_pins <= 3'h1;
      pt(5'h08);
      qchk(1'b1);
      pt(5'h00);
      qchk(1'b0);
      global_clock_pins <= 3'h0;
      pt(5'h08);
      qchk(1'b0);
      c.latch = 1'b0;
      c.d_sel = mcl_pkg::D_XOR;
      c.xor_sel = mcl_pkg::XOR_HI;
      wc();
      pt(5'h00);
      gpulse();
      qchk(1'b1);
      c.xor_sel = mcl_pkg::XOR_LO;
      wc();
      gpulse();
      qchk(1'b0);
      c.xor_sel = mcl_pkg::XOR_PT;
      wc();
      pt(5'h10);
      gpulse();
      qchk(1'b0);
      c.xor_sel = mcl_pkg::XOR_Q;
      wc();
      pt(5'h08);
      gpulse();
      qchk(1'b1);
      gpulse();
      qchk(1'b0);
      c.d_sel = mcl_pkg::D_PT;
      for (int i = 0; i < 8; i++) begin
         c.ar_sel = 2'(i / 2);
         wc();
         pt(5'h08);
         gpulse();
         @(posedge ref_clk);
         if (i % 2 == 0) global_clear_input <= 1'b1;
         else pterm <= 5'h0A;
         step(3);
         qchk(!(i / 2 == 3 || i / 2 == 1 + i % 2));
         global_clear_input <= 1'b0;
      end
      c.ap_en = 1'b1;
      c.ar_sel = mcl_pkg::AR_PT;
      wc();
      pt(5'h00);
      gpulse();
      pt(5'h01);
      qchk(1'b1);
      pt(5'h03);
      qchk(1'b0);
      c.ap_en = 1'b0;
      c.ar_sel = mcl_pkg::AR_OFF;
      c.out_reg = 1'b1;
      c.fb_reg = 1'b1;
      c.out_pol = 1'b1;
      wc();
      pt(5'h08);
      gpulse();
      pt(5'h00);
      chk_pin("io_out", 1'b0, io_out);
      chk_pin("feedback_out", 1'b1, feedback_out);
      c.out_reg = 1'b0;
      c.fb_reg = 1'b0;
      c.xor_sel = mcl_pkg::XOR_LO;
      wc();
      chk_pin("io_out", 1'b1, io_out);
      chk_pin("feedback_out", 1'b0, feedback_out);
      oe_tab = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
      oe_exp = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
      oe_pins <= 2'h1;
      oe_io_pins <= 4'h4;
      oe_mc_outs <= 4'hB;
      io.io_mode = 2'h2;
      io.oe_idx = 2'h2;
      for (int i = 0; i < 8; i++) begin
         io.oe_sel = oe_tab[i];
         wi();
         chk_pin("io_oe", oe_exp[i], io_oe);
      end
      io.io_mode = mcl_pkg::IO_IN;
      io.fold_sel = 3'h3;
      wi();
      chk_pin("io_oe", 1'b0, io_oe);
      pt(5'h08);
      chk_pin("foldback_out", 1'b0, foldback_out);
      pt(5'h00);
      chk_pin("foldback_out", 1'b1, foldback_out);
      c.d_sel = mcl_pkg::D_PIN;
      c.keeper = 1'b1;
      wc();
      drv_req <= 1'b1;
      drv_val <= 1'b1;
      step(3);
      drv_req <= 1'b0;
      step(3);
      gpulse();
      qchk(1'b1);
      c.keeper = 1'b0;
      wc();
      gpulse();
      qchk(1'b0);
      c.d_sel = mcl_pkg::D_PT;
      c.fb_reg = 1'b1;
      c.pd_en = 1'b1;
      wc();
      powerdown_pin_a <= 1'b1;
      step(3);
      chk_pin("powered_down", 1'b1, powered_down);
      pt(5'h08);
      gpulse();
      chk_pin("feedback_out", 1'b0, feedback_out);
      powerdown_pin_a <= 1'b0;
      step(3);
      chk_pin("powered_down", 1'b0, powered_down);
      gpulse();
      chk_pin("feedback_out", 1'b1, feedback_out);
      powerdown_pin_b <= 1'b1;
      step(3);
      chk_pin("powered_down", 1'b1, powered_down);
      c.pd_en = 1'b0;
      wr(mcl_pkg::REG_CORE, 32'(c));
      step(3);
      chk_pin("powered_down", 1'b0, powered_down);
      powerdown_pin_b <= 1'b0;
      wr(mcl_pkg::REG_MTX, 32'h0000_0005);
      wr(mcl_pkg::REG_MTX, 32'h0027_0043);
      gbus <= 68'h8_0000_0000_0000_0020;
      step(3);
      chk_pin("matrix_out0", 1'b1, matrix_out[0]);
      chk_pin("matrix_out39", 1'b1, matrix_out[39]);
      gbus <= '0;
      step(3);
      chk_pin("matrix_out0", 1'b0, matrix_out[0]);
      io.fold_mask = 4'h2;
      io.sum_mask = 5'h00;
      wi();
      fold_in <= 4'hD;
      step(3);
      chk_pin("cascade_out", 1'b0, cascade_out);
      fold_in <= 4'h2;
      step(3);
      chk_pin("cascade_out", 1'b1, cascade_out);
      c.pd_own = 1'b1;
      io.io_mode = mcl_pkg::IO_OUT;
      wi();
      wc();
      chk_pin("io_oe", 1'b0, io_oe);
      c.stby_en = 1'b1;
      wc();
      step(2);
      chk_pin("standby", 1'b1, standby);
      give_verdict();
   end
endmodule
`default_nettype wire
